// >>> hw/bcs_charge_sequencer.sv
// Battery charge sequencer: input qualification, suspend handover, ideal
// diode enable, charge phases, timers, recharge and the status pin.
// Assumes analog comparators deliver levels asynchronous to clk_sys and
// an external pull-up on the open-drain status pin.
`include "bcs_consts.svh"
`default_nettype none

module bcs_charge_sequencer #(
	parameter int unsigned TICK_CYCLES       = `BCS_TICK_US * (`BCS_CLK_HZ / `BCS_HZ_PER_MHZ),
	parameter int unsigned TRICKLE_TICKS     = `BCS_TRICKLE_LIMIT_S * (`BCS_US_PER_S / `BCS_TICK_US),
	parameter int unsigned SAFETY_TICKS      = `BCS_SAFETY_S * (`BCS_US_PER_S / `BCS_TICK_US),
	parameter int unsigned DEGLITCH_CYCLES   = `BCS_DEGLITCH_US * (`BCS_CLK_HZ / `BCS_HZ_PER_MHZ),
	parameter int unsigned THERM_BLINK_PERIODS =
		`BCS_PWM_HZ * `BCS_MHZ_PER_HZ / (2 * `BCS_THERM_BLINK_MHZ),
	parameter int unsigned BAD_BLINK_PERIODS =
		`BCS_PWM_HZ * `BCS_MHZ_PER_HZ / (2 * `BCS_BAD_BLINK_MHZ)
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire bcs_pkg::bcs_sense_type sense,
	output var  bcs_pkg::bcs_power_type power,
	output var  bcs_pkg::bcs_state_type charge_phase,
	input  wire logic                  charge_status_output_in,
	output var  logic                  charge_status_output_out,
	output var  logic                  charge_status_output_oe
);
	import bcs_pkg::*;

	localparam int SENSE_W = $bits(bcs_sense_type);

	// Three-stage synchronisers, a change counts once stages two and three agree
	logic [SENSE_W-1:0] sense_s1_reg;
	logic [SENSE_W-1:0] sense_s2_reg;
	logic [SENSE_W-1:0] sense_s3_reg;
	logic [SENSE_W-1:0] sense_filt_reg;
	bcs_sense_type      q;

	generate
		for (genvar i = 0; i < SENSE_W; i++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					sense_s1_reg[i]   <= 1'b0;
					sense_s2_reg[i]   <= 1'b0;
					sense_s3_reg[i]   <= 1'b0;
					sense_filt_reg[i] <= 1'b0;
				end else begin
					sense_s1_reg[i] <= sense[i];
					sense_s2_reg[i] <= sense_s1_reg[i];
					sense_s3_reg[i] <= sense_s2_reg[i];
					if (sense_s2_reg[i] == sense_s3_reg[i]) begin
						sense_filt_reg[i] <= sense_s3_reg[i];
					end
				end
			end
		end
	endgenerate

	assign q = bcs_sense_type'(sense_filt_reg);

	// Shared time base; long intervals count ticks, not cycles, to keep
	// the timers narrow
	logic [`BCS_TIMER_W-1:0] tick_cnt_reg;
	logic                    tick;

	assign tick = (tick_cnt_reg == `BCS_TIMER_W'(TICK_CYCLES - 1));

	always_ff @(posedge clk_sys) begin
		if (reset || tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + `BCS_TIMER_W'(1);
		end
	end

	// Input qualification with hysteresis; trip wins over qualify
	logic uvlo_ok_reg;
	logic power_ok;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			uvlo_ok_reg <= 1'b0;
		end else if (q.bus_fall_trip) begin
			uvlo_ok_reg <= 1'b0;
		end else if (q.bus_rise_ok) begin
			uvlo_ok_reg <= 1'b1;
		end
	end

	// Charging needs the switcher, which suspend turns off
	assign power_ok = uvlo_ok_reg && !q.bus_suspend;

	// Recharge deglitch: counter saturates one past the limit, so the
	// event fires once per continuous excursion
	logic [`BCS_TIMER_W-1:0] dglt_cnt_reg;
	logic                    recharge_event;

	always_ff @(posedge clk_sys) begin
		if (reset || !q.bat_below_recharge) begin
			dglt_cnt_reg <= '0;
		end else if (dglt_cnt_reg <= `BCS_TIMER_W'(DEGLITCH_CYCLES)) begin
			dglt_cnt_reg <= dglt_cnt_reg + `BCS_TIMER_W'(1);
		end
	end

	assign recharge_event = q.bat_below_recharge
		&& (dglt_cnt_reg == `BCS_TIMER_W'(DEGLITCH_CYCLES));

	// Charge phase machine
	bcs_state_type           state_reg;
	bcs_state_type           state_next;
	bcs_state_type           start_state;
	logic [`BCS_TIMER_W-1:0] trickle_time_reg;
	logic [`BCS_TIMER_W-1:0] safety_time_reg;
	logic                    trickle_expired;
	logic                    safety_expired;
	logic                    charging;

	// Deep-discharge check made only when a cycle begins
	assign start_state = q.bat_below_trickle ? BCS_ST_TRICKLE : BCS_ST_CC;

	assign trickle_expired = (trickle_time_reg > `BCS_TIMER_W'(TRICKLE_TICKS));
	assign safety_expired  = (safety_time_reg >= `BCS_TIMER_W'(SAFETY_TICKS));

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BCS_ST_OFF: begin
				// Loss of input always lands here, so a return restarts afresh
				if (power_ok) begin
					state_next = start_state;
				end
			end
			BCS_ST_TRICKLE: begin
				if (!power_ok) begin
					state_next = BCS_ST_OFF;
				end else if (trickle_expired) begin
					state_next = BCS_ST_BAD;
				end else if (!q.bat_below_trickle) begin
					state_next = BCS_ST_CC;
				end
			end
			BCS_ST_CC: begin
				if (!power_ok) begin
					state_next = BCS_ST_OFF;
				end else if (q.bat_at_float) begin
					state_next = BCS_ST_CV;
				end
			end
			BCS_ST_CV: begin
				if (!power_ok) begin
					state_next = BCS_ST_OFF;
				end else if (safety_expired) begin
					state_next = BCS_ST_DONE;
				end
			end
			BCS_ST_DONE: begin
				if (!power_ok) begin
					state_next = BCS_ST_OFF;
				end else if (recharge_event) begin
					state_next = start_state;
				end
			end
			BCS_ST_BAD: begin
				// Bad cell latches until the input drops out
				if (!power_ok) begin
					state_next = BCS_ST_OFF;
				end
			end
			default: begin
				state_next = BCS_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= BCS_ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	assign charging = (state_reg == BCS_ST_TRICKLE) || (state_reg == BCS_ST_CC)
		|| (state_reg == BCS_ST_CV);

	// Trickle timer keeps running through thermal pauses
	always_ff @(posedge clk_sys) begin
		if (reset || state_reg != BCS_ST_TRICKLE) begin
			trickle_time_reg <= '0;
		end else if (tick && !trickle_expired) begin
			trickle_time_reg <= trickle_time_reg + `BCS_TIMER_W'(1);
		end
	end

	// Safety timer runs only in float, held during thermal faults
	always_ff @(posedge clk_sys) begin
		if (reset || state_reg != BCS_ST_CV) begin
			safety_time_reg <= '0;
		end else if (recharge_event) begin
			safety_time_reg <= '0;
		end else if (tick && !q.thermistor_fault && !safety_expired) begin
			safety_time_reg <= safety_time_reg + `BCS_TIMER_W'(1);
		end
	end

	// Drive toward the power stage
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			power <= '0;
		end else begin
			power.ideal_diode_on  <= q.out_below_bat;
			power.switcher_en     <= uvlo_ok_reg && !q.bus_suspend;
			power.suspend_ldo_en  <= uvlo_ok_reg && q.bus_suspend;
			power.charge_en       <= charging && power_ok && !q.thermistor_fault;
			power.trickle_current <= (state_reg == BCS_ST_TRICKLE);
			power.float_regulate  <= (state_reg == BCS_ST_CV);
			power.yield_to_load   <= charging && q.input_current_limit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			charge_phase <= BCS_ST_OFF;
		end else begin
			charge_phase <= state_reg;
		end
	end

	// End-of-charge indication; a current-limited input can look like a
	// tapered current, so the tenth threshold is masked then
	logic end_of_charge_reg;

	always_ff @(posedge clk_sys) begin
		if (reset || (state_reg != BCS_ST_CV && state_reg != BCS_ST_DONE)) begin
			end_of_charge_reg <= 1'b0;
		end else if (state_reg == BCS_ST_CV && q.bat_at_float && q.current_below_tenth
				&& !q.input_current_limit) begin
			end_of_charge_reg <= 1'b1;
		end
	end

	// Status pin
	bcs_fault_type fault_kind;
	logic          pwm_pull;

	always_comb begin
		fault_kind = BCS_FLT_NONE;
		if (state_reg == BCS_ST_BAD) begin
			fault_kind = BCS_FLT_BAD;
		end else if (charging && q.thermistor_fault) begin
			fault_kind = BCS_FLT_THERM;
		end
	end

	bcs_status_pwm #(
		.THERM_BLINK_PERIODS (THERM_BLINK_PERIODS),
		.BAD_BLINK_PERIODS   (BAD_BLINK_PERIODS)
	) u_status_pwm (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.fault    (fault_kind),
		.pull_low (pwm_pull)
	);

	// Open drain: only ever drives low, enable carries the pattern
	assign charge_status_output_out = 1'b0;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			charge_status_output_oe <= 1'b0;
		end else if (fault_kind != BCS_FLT_NONE) begin
			charge_status_output_oe <= pwm_pull;
		end else begin
			charge_status_output_oe <= charging && !end_of_charge_reg;
		end
	end

endmodule

`default_nettype wire

// >>> hw/bcs_consts.svh
// Named constants for the battery charge sequencer: clock rate, time base,
// charger intervals and status pulse train figures.
// Assumes inclusion by bare name from every design file that needs a figure.
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

`define BCS_CLK_HZ          125000000
`define BCS_HZ_PER_MHZ      1000000
`define BCS_US_PER_S        1000000
`define BCS_MHZ_PER_HZ      1000

// Internal time base, one tick per period
`define BCS_TICK_US         1000

// Charger intervals, in their own units
`define BCS_TRICKLE_LIMIT_S 1800
`define BCS_SAFETY_S        14400
`define BCS_DEGLITCH_US     1300

// Timer and counter widths
`define BCS_TIMER_W         32
`define BCS_STEP_W          8
`define BCS_PHASE_W         4
`define BCS_BLINK_W         16

// Status pulse train: 35 kHz carrier cut into sixteen duty steps
`define BCS_PWM_HZ          35000
`define BCS_PWM_STEPS       16
`define BCS_STEP_CYCLES     (`BCS_CLK_HZ / (`BCS_PWM_HZ * `BCS_PWM_STEPS))

// Duty in sixteenths of a carrier period the pin is pulled low
`define BCS_DUTY_THERM_LO   4'h1
`define BCS_DUTY_THERM_HI   4'hf
`define BCS_DUTY_BAD_LO     4'h2
`define BCS_DUTY_BAD_HI     4'he

// Blink rates in millihertz, each duty level held for half a blink
`define BCS_THERM_BLINK_MHZ 1500
`define BCS_BAD_BLINK_MHZ   6100

`endif

// >>> hw/bcs_pkg.sv
// Types shared by the battery charge sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package bcs_pkg;

	typedef enum logic [2:0] {
		BCS_ST_OFF     = 3'h0,
		BCS_ST_TRICKLE = 3'h1,
		BCS_ST_CC      = 3'h3,
		BCS_ST_CV      = 3'h2,
		BCS_ST_DONE    = 3'h6,
		BCS_ST_BAD     = 3'h7
	} bcs_state_type;

	typedef enum logic [1:0] {
		BCS_FLT_NONE  = 2'h0,
		BCS_FLT_THERM = 2'h1,
		BCS_FLT_BAD   = 2'h2
	} bcs_fault_type;

	// Comparator and configuration levels from the analog side
	typedef struct packed {
		logic bus_suspend;
		logic bus_rise_ok;
		logic bus_fall_trip;
		logic bat_below_trickle;
		logic bat_at_float;
		logic bat_below_recharge;
		logic current_below_tenth;
		logic input_current_limit;
		logic thermistor_fault;
		logic out_below_bat;
	} bcs_sense_type;

	// Enables and selects toward the analog side
	typedef struct packed {
		logic switcher_en;
		logic suspend_ldo_en;
		logic ideal_diode_on;
		logic charge_en;
		logic trickle_current;
		logic float_regulate;
		logic yield_to_load;
	} bcs_power_type;

endpackage

`default_nettype wire

// >>> hw/bcs_status_pwm.sv
// Fault pulse generator for the charge status pin: 35 kHz carrier whose
// duty swaps between a low and a high value at a per-fault blink rate.
// Assumes one clock, synchronous active-high reset, fault from same domain.
`include "bcs_consts.svh"
`default_nettype none

module bcs_status_pwm #(
	parameter int unsigned THERM_BLINK_PERIODS = 11666,
	parameter int unsigned BAD_BLINK_PERIODS   = 2868
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire bcs_pkg::bcs_fault_type fault,
	output var  logic                  pull_low
);
	import bcs_pkg::*;

	logic [`BCS_STEP_W-1:0]  step_reg;
	logic [`BCS_PHASE_W-1:0] phase_reg;
	logic [`BCS_BLINK_W-1:0] blink_reg;
	logic                    level_high_reg;
	logic                    period_end;
	logic [`BCS_BLINK_W-1:0] blink_limit;
	logic [`BCS_PHASE_W-1:0] duty;
	bcs_fault_type           fault_prev_reg;

	assign period_end = (step_reg == `BCS_STEP_W'(`BCS_STEP_CYCLES - 1))
		&& (phase_reg == `BCS_PHASE_W'(`BCS_PWM_STEPS - 1));

	always_comb begin
		blink_limit = `BCS_BLINK_W'(THERM_BLINK_PERIODS - 1);
		duty        = level_high_reg ? `BCS_DUTY_THERM_HI : `BCS_DUTY_THERM_LO;
		if (fault == BCS_FLT_BAD) begin
			blink_limit = `BCS_BLINK_W'(BAD_BLINK_PERIODS - 1);
			duty        = level_high_reg ? `BCS_DUTY_BAD_HI : `BCS_DUTY_BAD_LO;
		end
	end

	// Carrier: sixteen steps of equal length form one period
	always_ff @(posedge clk_sys) begin
		fault_prev_reg <= reset ? BCS_FLT_NONE : fault;
		if (reset || fault == BCS_FLT_NONE || fault != fault_prev_reg) begin
			step_reg  <= '0;
			phase_reg <= '0;
		end else if (step_reg == `BCS_STEP_W'(`BCS_STEP_CYCLES - 1)) begin
			step_reg  <= '0;
			phase_reg <= phase_reg + `BCS_PHASE_W'(1);
		end else begin
			step_reg <= step_reg + `BCS_STEP_W'(1);
		end
	end

	// Blink: swap duty level every half blink, counted in whole periods
	// so a swap never cuts a carrier period short
	always_ff @(posedge clk_sys) begin
		if (reset || fault == BCS_FLT_NONE || fault != fault_prev_reg) begin
			blink_reg      <= '0;
			level_high_reg <= 1'b0;
		end else if (period_end) begin
			if (blink_reg >= blink_limit) begin
				blink_reg      <= '0;
				level_high_reg <= ~level_high_reg;
			end else begin
				blink_reg <= blink_reg + `BCS_BLINK_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || fault == BCS_FLT_NONE) begin
			pull_low <= 1'b0;
		end else begin
			pull_low <= (phase_reg < duty);
		end
	end

endmodule

`default_nettype wire

// >>> verification/battery_charge_sequencer_test.sv
// Self-checking bench for the battery charge sequencer.
// Assumes shortened timer parameters; phase changes are matched to notes.
`include "bcs_consts.svh"
`default_nettype none

module battery_charge_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bcs_pkg::*;

	localparam int FLOAT_MV = 4200;
	localparam int STEP = `BCS_STEP_CYCLES;
	localparam int PERIOD = `BCS_PWM_STEPS * STEP;
	// Periods per duty level, short so a few periods show both levels
	localparam int THERM_BLINK = 2;
	localparam int BAD_BLINK = 1;

	logic           clk_sys = 1'b0;
	logic           reset;
	int             bus_mv;
	int             bat_mv;
	bcs_sense_type  flags;
	bcs_sense_type  sense;
	bcs_power_type  power;
	bcs_state_type  charge_phase;
	bcs_state_type  last_phase = BCS_ST_OFF;
	bcs_state_type  exp_q[$];
	logic           pin;
	logic           pin_out;
	logic           oe;
	logic [31:0]    seed;
	logic [31:0]    rnd;
	int             failures = 0;
	int             comparisons = 0;
	int             n;

	always #4 clk_sys = ~clk_sys;

	bcs_cell_model #(.FLOAT_MV(FLOAT_MV)) i_cell (
		.bus_mv (bus_mv),
		.bat_mv (bat_mv),
		.flags  (flags),
		.pin_out(pin_out),
		.pin_oe (oe),
		.sense  (sense),
		.pin    (pin)
	);

	bcs_charge_sequencer #(
		.TICK_CYCLES      (10),
		.TRICKLE_TICKS    (5),
		.SAFETY_TICKS     (40),
		.DEGLITCH_CYCLES  (20),
		.THERM_BLINK_PERIODS(THERM_BLINK),
		.BAD_BLINK_PERIODS  (BAD_BLINK)
	) i_dut (
		.clk_sys                 (clk_sys),
		.reset                   (reset),
		.sense                   (sense),
		.power                   (power),
		.charge_phase            (charge_phase),
		.charge_status_output_in (pin),
		.charge_status_output_out(pin_out),
		.charge_status_output_oe (oe)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int c);
		repeat (c) @(negedge clk_sys);
	endtask

	// Waits for every noted phase to appear, then lets outputs settle
	task automatic settle(input string name, input int bound);
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < bound) begin
			k++;
			@(negedge clk_sys);
		end
		if (exp_q.size() != 0) begin
			failures++;
			$display("Error at %0t: %s timed out", $time, name);
			complete_run();
		end
		cyc(3);
		$display("Finished %s", name);
	endtask

	// First period is partial and only aligns the count
	task automatic duty(input int lo, input int hi);
		int h;
		int p;
		int n_lo;
		int n_hi;
		n_lo = 0;
		n_hi = 0;
		for (int k = 0; k < 5; k++) begin
			h = 0;
			p = 0;
			while (oe === 1'b1 && p < 8000) begin
				h++;
				p++;
				@(negedge clk_sys);
			end
			while (oe !== 1'b1 && p < 8000) begin
				p++;
				@(negedge clk_sys);
			end
			if (k > 0 && h != PERIOD / 2) begin
				check(p, PERIOD);
				check(h == lo * STEP || h == hi * STEP, 1);
				n_lo += int'(h == lo * STEP);
				n_hi += int'(h == hi * STEP);
			end
		end
		check(n_lo > 0 && n_hi > 0, 1);
	endtask

	// Unexpected phase changes compare against the phase held before
	always @(negedge clk_sys) begin
		if (!reset && charge_phase !== last_phase) begin
			if (exp_q.size() == 0) begin
				check(charge_phase, last_phase);
			end else begin
				check(charge_phase, exp_q.pop_front());
			end
			last_phase = charge_phase;
		end
	end

	initial begin
		seed = 32'hbc36;
		reset = 1'b1;
		bus_mv = 0;
		bat_mv = 2500;
		flags = '0;
		cyc(4);
		reset = 1'b0;
		exp_q.push_back(BCS_ST_TRICKLE);
		bus_mv = 5000;
		settle("trickle start", 100);
		check(power.trickle_current, 1);
		check(power.switcher_en, 1);
		check(oe, 1);
		exp_q.push_back(BCS_ST_CC);
		bat_mv = 3700;
		settle("constant current", 100);
		check(power.trickle_current, 0);
		check(power.charge_en, 1);
		flags.input_current_limit = 1'b1;
		cyc(8);
		check(power.yield_to_load, 1);
		exp_q.push_back(BCS_ST_CV);
		bat_mv = FLOAT_MV;
		flags.current_below_tenth = 1'b1;
		settle("float", 100);
		cyc(8);
		check(oe, 1);
		check(power.float_regulate, 1);
		flags.input_current_limit = 1'b0;
		cyc(8);
		check(oe, 0);
		flags.thermistor_fault = 1'b1;
		cyc(10);
		duty(1, 15);
		flags.thermistor_fault = 1'b0;
		cyc(200);
		bat_mv = FLOAT_MV - 200;
		cyc(30);
		bat_mv = FLOAT_MV;
		exp_q.push_back(BCS_ST_DONE);
		n = 0;
		while (charge_phase !== BCS_ST_DONE && n < 1000) begin
			n++;
			@(negedge clk_sys);
		end
		check(n > 350 && n < 480, 1);
		settle("safety expiry", 10);
		check(power.charge_en, 0);
		check(oe, 0);
		rnd = $random(seed);
		bat_mv = FLOAT_MV - 200;
		cyc(5 + int'(rnd[3:0] % 10));
		bat_mv = FLOAT_MV;
		cyc(40);
		exp_q.push_back(BCS_ST_CC);
		bat_mv = FLOAT_MV - 200;
		settle("recharge", 100);
		exp_q.push_back(BCS_ST_OFF);
		flags.bus_suspend = 1'b1;
		settle("suspend", 100);
		check(power.switcher_en, 0);
		check(power.suspend_ldo_en, 1);
		exp_q.push_back(BCS_ST_CC);
		flags.bus_suspend = 1'b0;
		settle("resume", 100);
		exp_q.push_back(BCS_ST_OFF);
		bus_mv = bat_mv + 30;
		settle("lockout", 100);
		bus_mv = 4200;
		cyc(40);
		exp_q.push_back(BCS_ST_CC);
		bus_mv = 5000;
		settle("relock", 100);
		for (int i = 0; i < 8; i++) begin
			rnd = $random(seed);
			flags.out_below_bat = rnd[0];
			cyc(10);
			check(power.ideal_diode_on, flags.out_below_bat);
		end
		exp_q.push_back(BCS_ST_OFF);
		bus_mv = 3000;
		settle("supply loss", 100);
		exp_q.push_back(BCS_ST_TRICKLE);
		exp_q.push_back(BCS_ST_BAD);
		bat_mv = 2500;
		bus_mv = 5000;
		settle("bad cell", 500);
		check(power.charge_en, 0);
		duty(2, 14);
		complete_run();
	end
endmodule

`default_nettype wire

// >>> verification/bcs_cell_model.sv
// Cell, input supply and status pull-up seen by the sequencer.
// Assumes the bench sets voltages in millivolts; other levels pass through.
`default_nettype none

module bcs_cell_model #(
	parameter int FLOAT_MV = 4200
) (
	input var  int                     bus_mv,
	input var  int                     bat_mv,
	input wire bcs_pkg::bcs_sense_type flags,
	input wire logic                   pin_out,
	input wire logic                   pin_oe,
	output var bcs_pkg::bcs_sense_type sense,
	output wire logic                  pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import bcs_pkg::*;

	always_comb begin
		sense = flags;
		sense.bus_rise_ok = bus_mv > 4300 && bus_mv >= bat_mv + 200;
		sense.bus_fall_trip = bus_mv < 4000 || bus_mv < bat_mv + 50;
		sense.bat_below_trickle = bat_mv < 2850;
		sense.bat_at_float = bat_mv >= FLOAT_MV;
		sense.bat_below_recharge = bat_mv < FLOAT_MV - 100;
	end

	// Released pin goes to the pull-up level
	assign pin = pin_oe ? pin_out : 1'b1;
endmodule

`default_nettype wire

// >>> verification/bcs_charge_sequencer_monitor.sv
// Port-level checker for the battery charge sequencer.
// Assumes the design's reset flushes the input synchronisers to idle.
`default_nettype none

module bcs_charge_sequencer_monitor (
	input wire logic                   clk_sys,
	input wire logic                   reset,
	input wire bcs_pkg::bcs_sense_type sense,
	input wire bcs_pkg::bcs_power_type power,
	input wire bcs_pkg::bcs_state_type charge_phase,
	input wire logic                   charge_status_output_in,
	input wire logic                   charge_status_output_out,
	input wire logic                   charge_status_output_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	import bcs_pkg::*;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Eight samples cover the synchroniser, filter and output register
	a_diode_on: assert property (sense.out_below_bat [*8] |=> power.ideal_diode_on)
		else $error("ideal diode not enabled");
	a_diode_off: assert property (!sense.out_below_bat [*8] |=> !power.ideal_diode_on)
		else $error("ideal diode left enabled");
	a_ldo_excl: assert property (power.suspend_ldo_en |-> !power.switcher_en)
		else $error("suspend regulator beside switcher");
	a_suspend_off: assert property (sense.bus_suspend [*8] |=> !power.switcher_en)
		else $error("switcher on while suspended");
	a_trip_off: assert property (sense.bus_fall_trip [*8] |=> charge_phase == BCS_ST_OFF && !power.switcher_en)
		else $error("charger active after input trip");
	a_trickle_tenth: assert property (charge_phase == BCS_ST_TRICKLE [*3] |-> power.trickle_current)
		else $error("trickle without tenth current");
	a_bad_latch: assert property (charge_phase == BCS_ST_BAD |=> charge_phase inside {BCS_ST_BAD, BCS_ST_OFF})
		else $error("bad cell state left");
	a_cv_from_cc: assert property ($changed(charge_phase) && charge_phase == BCS_ST_CV |-> $past(charge_phase) == BCS_ST_CC)
		else $error("float phase entered out of order");
	a_done_from_cv: assert property ($changed(charge_phase) && charge_phase == BCS_ST_DONE |-> $past(charge_phase) == BCS_ST_CV)
		else $error("termination entered out of order");
	a_done_quiet: assert property (charge_phase == BCS_ST_DONE [*3] |-> !power.charge_en && !charge_status_output_oe)
		else $error("charging or status low after end");
	a_charging_low: assert property ((charge_phase == BCS_ST_CC && !sense.thermistor_fault) [*8] |-> charge_status_output_oe)
		else $error("status released while charging");
	a_pin_low: assert property (charge_status_output_out == 1'b0)
		else $error("open-drain pin drives high");

	c_bad: cover property (charge_phase == BCS_ST_BAD);
	c_cv_therm: cover property (charge_phase == BCS_ST_CV && sense.thermistor_fault);
	c_recharge: cover property (charge_phase == BCS_ST_DONE ##1 charge_phase == BCS_ST_CC);
endmodule

bind bcs_charge_sequencer bcs_charge_sequencer_monitor i_mon (
	.clk_sys                 (clk_sys),
	.reset                   (reset),
	.sense                   (sense),
	.power                   (power),
	.charge_phase            (charge_phase),
	.charge_status_output_in (charge_status_output_in),
	.charge_status_output_out(charge_status_output_out),
	.charge_status_output_oe (charge_status_output_oe)
);

`default_nettype wire
